// >>> rtl/uep0_pkg.sv
// constants and types shared by the endpoint-zero control logic
package uep0_pkg;
   // register offsets
   localparam logic [7:0] OFF_CSR = 8'h11;
   localparam logic [7:0] OFF_COUNT = 8'h16;
   localparam logic [7:0] OFF_FIFO = 8'h20;
   // control/status field positions
   localparam int BIT_OUT_RDY = 0;
   localparam int BIT_IN_RDY = 1;
   localparam int BIT_STALL_SENT = 2;
   localparam int BIT_LAST_DATA = 3;
   localparam int BIT_SETUP_END = 4;
   localparam int BIT_FORCE_STALL = 5;
   localparam int BIT_OUT_SERVICED = 6;
   localparam int BIT_SETUP_END_ACK = 7;
   localparam int FLAG_COUNT = 6;
   localparam logic [7:0] CSR_RESET = 8'h00;
   // packet sizes
   localparam logic [6:0] MAX_PKT = 7'h40;
   localparam logic [6:0] SETUP_LEN = 7'h08;
   localparam int FIFO_DEPTH = 64;
   // token kinds from the serial engine
   localparam logic [1:0] TOK_SETUP = 2'h0;
   localparam logic [1:0] TOK_OUT = 2'h1;
   localparam logic [1:0] TOK_IN = 2'h2;
   // handshake codes to the serial engine
   localparam logic [1:0] HS_ACK = 2'h0;
   localparam logic [1:0] HS_NAK = 2'h1;
   localparam logic [1:0] HS_STALL = 2'h2;
   typedef enum logic [1:0] {MODE_IDLE, MODE_TX, MODE_RX} uep0_mode_t;
endpackage

// >>> rtl/uep0_flag_if.sv
// set/clear/value bundle of one sticky status flag
interface uep0_flag_if;
   logic set;
   logic clr;
   logic q;
   modport owner (input set, input clr, output q);
   modport user (output set, output clr, input q);
endinterface

// >>> rtl/uep0_flag.sv
// sticky flag cell: a set in the same cycle as a clear wins
module uep0_flag
(
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // flag bundle
   uep0_flag_if.owner fl
);
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         fl.q <= 1'b0;
      else if (fl.set)
         fl.q <= 1'b1;
      else if (fl.clr)
         fl.q <= 1'b0;
   end
endmodule

// >>> rtl/uep0_ctrl.sv
// endpoint-zero control transfer logic with its control/status register
//
// Functional notes
// RQ1: host opens each transfer with eight-byte SETUP
// RQ2: SETUP not eight bytes is dropped silently
// RQ3: loaded SETUP raises endpoint interrupt
// RQ4: firmware reads SETUP, then sets out_serviced
// RQ5: firmware loads FIFO then sets in_packet_ready
// RQ6: interrupt on sent IN, none on NAK
// RQ7: IN token NAKed while in_packet_ready clear
// RQ8: firmware splits long IN data, sets last_data
// RQ9: first IN enters transmit; SETUP/OUT flags setup_end
// RQ10: transmit ends on SETUP/OUT or short packet
// RQ11: firmware sets last_data with short packet
// RQ12: good OUT sets out_packet_ready and interrupts
// RQ13: firmware unloads OUT then sets out_serviced
// RQ14: host ends exact-multiple OUT with empty packet
// RQ15: first OUT enters receive; SETUP/IN flags setup_end
// RQ16: receive ends on SETUP/IN or short packet
// RQ17: OUT after last_data is STALLed
// RQ18: sent STALL sets stall_sent and interrupts
// RQ19: setup_end_ack clears setup_end, reads zero
// RQ20: out_serviced write clears out_packet_ready
// RQ21: transfer ended early flags setup_end, interrupts
// RQ22: count register reports FIFO bytes
// RQ23: force_stall aborts; cleared after STALL sent
// RQ24: oversize packet answered with STALL
// RQ25: new SETUP idles mode and clears last_data
module uep0_ctrl
   import uep0_pkg::*;
(
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RST_IN,
   // register port
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic [7:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   output logic [7:0] REG_RDATA_OUT,
   // tokens and received data from the serial engine
   input wire logic TOK_VALID_IN,
   input wire logic [1:0] TOK_KIND_IN,
   input wire logic TOK_EP0_IN,
   input wire logic RX_BYTE_VALID_IN,
   input wire logic [7:0] RX_BYTE_IN,
   input wire logic RX_DONE_IN,
   input wire logic RX_BAD_IN,
   // transmit side of the serial engine
   input wire logic TX_POP_IN,
   input wire logic TX_ACK_IN,
   output logic TX_REQ_OUT,
   output logic [6:0] TX_LEN_OUT,
   output logic [7:0] TX_BYTE_OUT,
   // handshake answer and status
   output logic HS_VALID_OUT,
   output logic [1:0] HS_CODE_OUT,
   output logic EP0_IRQ_OUT,
   output logic [1:0] MODE_OUT
);
   ////////////////////////////////////////////////////////////////////////////
   // flags
   logic [FLAG_COUNT-1:0] flag_set;
   logic [FLAG_COUNT-1:0] flag_clr;
   logic [FLAG_COUNT-1:0] flag_q;
   uep0_flag_if fl [FLAG_COUNT] ();

   genvar gi;
   generate
      for (gi = 0; gi < FLAG_COUNT; gi++)
      begin : g_flag
         assign fl[gi].set = flag_set[gi];
         assign fl[gi].clr = flag_clr[gi];
         assign flag_q[gi] = fl[gi].q;
         uep0_flag u_flag
         (
            .clk_in(CLK_IN),
            .rst_in(RST_IN),
            .fl(fl[gi])
         );
      end
   endgenerate

   logic out_rdy;
   logic in_rdy;
   logic last_data;
   logic force_stall;
   assign out_rdy = flag_q[BIT_OUT_RDY];
   assign in_rdy = flag_q[BIT_IN_RDY];
   assign last_data = flag_q[BIT_LAST_DATA];
   assign force_stall = flag_q[BIT_FORCE_STALL];

   ////////////////////////////////////////////////////////////////////////////
   // state
   uep0_mode_t mode_reg;
   uep0_mode_t mode_next;
   logic [7:0] mem [FIFO_DEPTH];
   logic [6:0] wr_ptr_reg;
   logic [6:0] rd_ptr_reg;
   logic [6:0] rx_len_reg;
   logic [1:0] tok_kind_reg;
   logic tok_live_reg;
   logic rx_store_reg;
   logic tx_busy_reg;
   logic [6:0] count;

   assign count = wr_ptr_reg - rd_ptr_reg;

   logic wr_csr;
   logic wr_fifo;
   logic rd_fifo;
   assign wr_csr = REG_WR_IN && (REG_ADDR_IN == OFF_CSR);
   assign wr_fifo = REG_WR_IN && (REG_ADDR_IN == OFF_FIFO);
   assign rd_fifo = REG_RD_IN && (REG_ADDR_IN == OFF_FIFO);

   ////////////////////////////////////////////////////////////////////////////
   // token and packet decisions
   logic tok_ep0;
   logic setup_tok;
   logic in_tok;
   logic out_done;
   logic setup_done;
   logic rx_oversize;
   logic load_ev;
   logic stall_ev;
   logic nak_ev;
   logic ack_ev;
   logic tx_start;
   logic setup_end_ev;
   logic tx_sent;
   logic tx_short;

   always_comb
   begin
      tok_ep0 = TOK_VALID_IN && TOK_EP0_IN;
      setup_tok = tok_ep0 && (TOK_KIND_IN == TOK_SETUP);
      in_tok = tok_ep0 && (TOK_KIND_IN == TOK_IN);
      setup_done = RX_DONE_IN && tok_live_reg && (tok_kind_reg == TOK_SETUP);
      out_done = RX_DONE_IN && tok_live_reg && (tok_kind_reg == TOK_OUT);
      rx_oversize = rx_len_reg > MAX_PKT;
      load_ev = 1'b0;
      stall_ev = 1'b0;
      nak_ev = 1'b0;
      ack_ev = 1'b0;
      tx_start = 1'b0;
      // a SETUP of the wrong length gets neither load nor handshake
      if (setup_done && (rx_len_reg == SETUP_LEN)) //RQ2
      begin
         load_ev = 1'b1; //RQ3
         ack_ev = 1'b1;
      end
      if (out_done)
      begin
         if (force_stall || rx_oversize) //RQ24
            stall_ev = 1'b1; //RQ23
         else if (last_data && (mode_reg == MODE_RX)) //RQ17
            stall_ev = 1'b1;
         else if (out_rdy || !rx_store_reg)
            nak_ev = 1'b1;
         else
         begin
            load_ev = 1'b1; //RQ12
            ack_ev = 1'b1;
         end
      end
      if (in_tok)
      begin
         if (force_stall) //RQ23
            stall_ev = 1'b1;
         else if (!in_rdy) //RQ7
            nak_ev = 1'b1;
         else
            tx_start = 1'b1;
      end
      // leaving a data phase by a foreign token ends the transfer early
      setup_end_ev = 1'b0;
      if (tok_ep0 && (mode_reg == MODE_TX) && (TOK_KIND_IN != TOK_IN)) //RQ9
         setup_end_ev = 1'b1; //RQ21
      if (tok_ep0 && (mode_reg == MODE_RX) && (TOK_KIND_IN != TOK_OUT)) //RQ15
         setup_end_ev = 1'b1; //RQ21
      tx_sent = TX_ACK_IN && tx_busy_reg;
      tx_short = tx_sent && (TX_LEN_OUT < MAX_PKT);
   end

   ////////////////////////////////////////////////////////////////////////////
   // flag set and clear terms
   always_comb
   begin
      flag_set = '0;
      flag_clr = '0;
      flag_set[BIT_OUT_RDY] = load_ev; //RQ12
      flag_clr[BIT_OUT_RDY] = wr_csr && REG_WDATA_IN[BIT_OUT_SERVICED]; //RQ20
      flag_set[BIT_IN_RDY] = wr_csr && REG_WDATA_IN[BIT_IN_RDY];
      flag_clr[BIT_IN_RDY] = tx_sent;
      flag_set[BIT_STALL_SENT] = stall_ev; //RQ18
      flag_clr[BIT_STALL_SENT] = wr_csr && !REG_WDATA_IN[BIT_STALL_SENT];
      flag_set[BIT_LAST_DATA] = wr_csr && REG_WDATA_IN[BIT_LAST_DATA];
      flag_clr[BIT_LAST_DATA] = setup_tok || tx_short; //RQ25
      flag_set[BIT_SETUP_END] = setup_end_ev;
      flag_clr[BIT_SETUP_END] = wr_csr && REG_WDATA_IN[BIT_SETUP_END_ACK]; //RQ19
      flag_set[BIT_FORCE_STALL] = wr_csr && REG_WDATA_IN[BIT_FORCE_STALL];
      flag_clr[BIT_FORCE_STALL] = stall_ev && force_stall; //RQ23
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit/receive mode
   always_comb
   begin
      mode_next = mode_reg;
      case (mode_reg)
         MODE_IDLE:
         begin
            if (in_tok)
               mode_next = MODE_TX; //RQ9
            else if (tok_ep0 && (TOK_KIND_IN == TOK_OUT))
               mode_next = MODE_RX; //RQ15
         end
         MODE_TX:
         begin
            if (tok_ep0 && (TOK_KIND_IN != TOK_IN))
               mode_next = MODE_IDLE; //RQ10
            else if (tx_short)
               mode_next = MODE_IDLE; //RQ10
         end
         MODE_RX:
         begin
            if (tok_ep0 && (TOK_KIND_IN != TOK_OUT))
               mode_next = MODE_IDLE; //RQ16
            else if (load_ev && (rx_len_reg < MAX_PKT))
               mode_next = MODE_IDLE; //RQ16
         end
         default:
            mode_next = MODE_IDLE;
      endcase
      if (setup_tok)
         mode_next = MODE_IDLE; //RQ25
   end

   always_ff @(posedge CLK_IN)
   begin
      if (RST_IN)
         mode_reg <= MODE_IDLE;
      else
         mode_reg <= mode_next;
   end

   always_ff @(posedge CLK_IN)
   begin
      if (RST_IN)
         MODE_OUT <= 2'h0;
      else
         MODE_OUT <= mode_next;
   end

   ////////////////////////////////////////////////////////////////////////////
   // token tracking for the data packet that follows
   always_ff @(posedge CLK_IN)
   begin
      if (RST_IN)
      begin
         tok_live_reg <= 1'b0;
         tok_kind_reg <= TOK_SETUP;
         rx_store_reg <= 1'b0;
      end
      else if (tok_ep0)
      begin
         tok_live_reg <= (TOK_KIND_IN != TOK_IN);
         tok_kind_reg <= TOK_KIND_IN;
         // a SETUP always overwrites; an OUT waits for a free FIFO
         rx_store_reg <= (TOK_KIND_IN == TOK_SETUP) || !out_rdy;
      end
      else if (TOK_VALID_IN || RX_DONE_IN || RX_BAD_IN)
      begin
         tok_live_reg <= 1'b0;
         rx_store_reg <= 1'b0;
      end
   end

   always_ff @(posedge CLK_IN)
   begin
      if (RST_IN)
         rx_len_reg <= 7'h00;
      else if (tok_ep0)
         rx_len_reg <= 7'h00;
      else if (RX_BYTE_VALID_IN && tok_live_reg && (rx_len_reg <= MAX_PKT))
         rx_len_reg <= rx_len_reg + 7'h01;
   end

   ////////////////////////////////////////////////////////////////////////////
   // FIFO storage and pointers
   logic rx_write;
   assign rx_write = RX_BYTE_VALID_IN && rx_store_reg && tok_live_reg && (rx_len_reg < MAX_PKT);

   always_ff @(posedge CLK_IN)
   begin
      if (rx_write)
         mem[rx_len_reg[5:0]] <= RX_BYTE_IN;
      else if (wr_fifo && (count < MAX_PKT) && !in_rdy)
         mem[wr_ptr_reg[5:0]] <= REG_WDATA_IN;
   end

   always_ff @(posedge CLK_IN)
   begin
      if (RST_IN)
      begin
         wr_ptr_reg <= 7'h00;
         rd_ptr_reg <= 7'h00;
      end
      else if (load_ev)
      begin
         wr_ptr_reg <= rx_len_reg;
         rd_ptr_reg <= 7'h00;
      end
      else if (tx_sent || (tok_ep0 && (TOK_KIND_IN == TOK_SETUP)))
      begin
         wr_ptr_reg <= 7'h00;
         rd_ptr_reg <= 7'h00;
      end
      else if (tx_start)
         rd_ptr_reg <= 7'h00;
      else if (TX_POP_IN && tx_busy_reg && (rd_ptr_reg < wr_ptr_reg))
         rd_ptr_reg <= rd_ptr_reg + 7'h01;
      else if (wr_fifo && (count < MAX_PKT) && !in_rdy)
         wr_ptr_reg <= wr_ptr_reg + 7'h01;
      else if (rd_fifo && (rd_ptr_reg < wr_ptr_reg))
         rd_ptr_reg <= rd_ptr_reg + 7'h01;
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit handoff
   always_ff @(posedge CLK_IN)
   begin
      if (RST_IN)
      begin
         tx_busy_reg <= 1'b0;
         TX_REQ_OUT <= 1'b0;
         TX_LEN_OUT <= 7'h00;
      end
      else
      begin
         TX_REQ_OUT <= tx_start;
         if (tx_start)
         begin
            tx_busy_reg <= 1'b1;
            TX_LEN_OUT <= wr_ptr_reg;
         end
         else if (tx_sent || tok_ep0)
            tx_busy_reg <= 1'b0;
      end
   end

   always_ff @(posedge CLK_IN)
   begin
      if (RST_IN)
         TX_BYTE_OUT <= 8'h00;
      else if (TX_POP_IN && tx_busy_reg)
         TX_BYTE_OUT <= mem[rd_ptr_reg[5:0]];
   end

   ////////////////////////////////////////////////////////////////////////////
   // handshake and interrupt pulses
   always_ff @(posedge CLK_IN)
   begin
      if (RST_IN)
      begin
         HS_VALID_OUT <= 1'b0;
         HS_CODE_OUT <= HS_ACK;
      end
      else
      begin
         HS_VALID_OUT <= stall_ev || nak_ev || ack_ev;
         if (stall_ev)
            HS_CODE_OUT <= HS_STALL; //RQ18
         else if (nak_ev)
            HS_CODE_OUT <= HS_NAK; //RQ7
         else
            HS_CODE_OUT <= HS_ACK;
      end
   end

   // a NAKed IN raises no interrupt of its own; loads, sent IN data, STALLs and setup_end do
   always_ff @(posedge CLK_IN)
   begin
      if (RST_IN)
         EP0_IRQ_OUT <= 1'b0;
      else
         EP0_IRQ_OUT <= load_ev || tx_sent || stall_ev || setup_end_ev; //RQ6
   end

   ////////////////////////////////////////////////////////////////////////////
   // register read port
   logic [7:0] csr_view;
   always_comb
   begin
      csr_view = CSR_RESET;
      csr_view[FLAG_COUNT-1:0] = flag_q;
   end

   always_ff @(posedge CLK_IN)
   begin
      if (RST_IN)
         REG_RDATA_OUT <= 8'h00;
      else if (REG_RD_IN)
      begin
         case (REG_ADDR_IN)
            OFF_CSR: REG_RDATA_OUT <= csr_view; //RQ19
            OFF_COUNT: REG_RDATA_OUT <= {1'b0, count}; //RQ22
            OFF_FIFO: REG_RDATA_OUT <= mem[rd_ptr_reg[5:0]];
            default: REG_RDATA_OUT <= 8'h00;
         endcase
      end
      else
         REG_RDATA_OUT <= 8'h00;
   end
endmodule

// >>> verif/uep0_ctrl_checker.sv
// port assertions for the endpoint-zero control block
module uep0_ctrl_checker
   import uep0_pkg::*;
(
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RST_IN,
   // register and link inputs
   input wire logic REG_RD_IN,
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic TOK_VALID_IN,
   input wire logic [1:0] TOK_KIND_IN,
   input wire logic TOK_EP0_IN,
   input wire logic RX_DONE_IN,
   input wire logic TX_ACK_IN,
   // outputs
   input wire logic [7:0] REG_RDATA_OUT,
   input wire logic TX_REQ_OUT,
   input wire logic HS_VALID_OUT,
   input wire logic [1:0] HS_CODE_OUT,
   input wire logic EP0_IRQ_OUT,
   input wire logic [1:0] MODE_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);
   logic tok_in;
   logic tok_out;
   logic tok_setup;
   logic cause;
   assign tok_in = TOK_VALID_IN && TOK_EP0_IN && TOK_KIND_IN == TOK_IN;
   assign tok_out = TOK_VALID_IN && TOK_EP0_IN && TOK_KIND_IN == TOK_OUT;
   assign tok_setup = TOK_VALID_IN && TOK_EP0_IN && TOK_KIND_IN == TOK_SETUP;
   assign cause = RX_DONE_IN || TX_ACK_IN || TOK_VALID_IN;
   ////////////////////////////////////////////////////////////////////////////////
   property p_ack_bits;
      $past(REG_RD_IN && REG_ADDR_IN == OFF_CSR) |-> REG_RDATA_OUT[7:6] == 2'h0;
   endproperty
   a_ack_bits: assert property (p_ack_bits) else $error("ack bits read one");
   property p_hs_cause;
      HS_VALID_OUT |-> $past(TOK_VALID_IN || RX_DONE_IN);
   endproperty
   a_hs_cause: assert property (p_hs_cause) else $error("handshake without cause");
   property p_data_or_hs;
      !(HS_VALID_OUT && TX_REQ_OUT);
   endproperty
   a_data_or_hs: assert property (p_data_or_hs) else $error("data and handshake");
   property p_tx_entry;
      $changed(MODE_OUT) && MODE_OUT == MODE_TX |-> $past(tok_in);
   endproperty
   a_tx_entry: assert property (p_tx_entry) else $error("transmit without IN");
   property p_rx_entry;
      $changed(MODE_OUT) && MODE_OUT == MODE_RX |-> $past(tok_out || RX_DONE_IN);
   endproperty
   a_rx_entry: assert property (p_rx_entry) else $error("receive without OUT");
   property p_setup_idle;
      tok_setup |=> MODE_OUT == MODE_IDLE;
   endproperty
   a_setup_idle: assert property (p_setup_idle) else $error("setup kept mode");
   property p_req_mode;
      TX_REQ_OUT |-> ##[0:1] MODE_OUT == MODE_TX;
   endproperty
   a_req_mode: assert property (p_req_mode) else $error("send outside transmit");
   property p_stall_irq;
      HS_VALID_OUT && HS_CODE_OUT == HS_STALL |-> ##[0:1] EP0_IRQ_OUT;
   endproperty
   a_stall_irq: assert property (p_stall_irq) else $error("stall without irq");
   property p_ack_irq;
      HS_VALID_OUT && HS_CODE_OUT == HS_ACK |-> EP0_IRQ_OUT;
   endproperty
   a_ack_irq: assert property (p_ack_irq) else $error("load without irq");
   property p_irq_cause;
      EP0_IRQ_OUT |-> $past(cause) || $past(cause, 2);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
   c_ack: cover property (HS_VALID_OUT && HS_CODE_OUT == HS_ACK);
   c_stall: cover property (HS_VALID_OUT && HS_CODE_OUT == HS_STALL);
   c_req: cover property (TX_REQ_OUT);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind uep0_ctrl uep0_ctrl_checker chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
   .REG_RD_IN(REG_RD_IN), .REG_ADDR_IN(REG_ADDR_IN), .TOK_VALID_IN(TOK_VALID_IN),
   .TOK_KIND_IN(TOK_KIND_IN), .TOK_EP0_IN(TOK_EP0_IN), .RX_DONE_IN(RX_DONE_IN),
   .TX_ACK_IN(TX_ACK_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .TX_REQ_OUT(TX_REQ_OUT),
   .HS_VALID_OUT(HS_VALID_OUT), .HS_CODE_OUT(HS_CODE_OUT), .EP0_IRQ_OUT(EP0_IRQ_OUT),
   .MODE_OUT(MODE_OUT));

// >>> verif/uep0_host.sv
// behavioural host and serial engine facing endpoint zero
module uep0_host
   import uep0_pkg::*;
(
   // clock
   input wire logic clk_in,
   // transmit side of the block
   input wire logic tx_req_in,
   input wire logic [6:0] tx_len_in,
   input wire logic [7:0] tx_byte_in,
   // link stimulus
   output logic tok_v_out,
   output logic [1:0] tok_k_out,
   output logic rx_v_out,
   output logic [7:0] rx_b_out,
   output logic rx_done_out,
   output logic pop_out,
   output logic ack_out
);
   timeunit 1ns;
   timeprecision 1ns;
   int slow = 0;
   int n;
   logic [7:0] got[$];
   initial
   begin
      tok_v_out = 1'b0;
      tok_k_out = 2'h0;
      rx_v_out = 1'b0;
      rx_b_out = 8'h55;
      rx_done_out = 1'b0;
      pop_out = 1'b0;
      ack_out = 1'b0;
   end
   task automatic token(input logic [1:0] k);
      tok_v_out <= 1'b1;
      tok_k_out <= k;
      @(posedge clk_in);
      tok_v_out <= 1'b0;
      @(posedge clk_in);
   endtask
   // released data line shows the inverse of its last byte
   task automatic send(input logic [1:0] k, input int len);
      token(k);
      for (int i = 0; i < len; i++)
      begin
         rx_v_out <= 1'b1;
         rx_b_out <= 8'(i);
         @(posedge clk_in);
      end
      rx_v_out <= 1'b0;
      rx_b_out <= ~rx_b_out;
      rx_done_out <= 1'b1;
      @(posedge clk_in);
      rx_done_out <= 1'b0;
      @(posedge clk_in);
   endtask
   // pulls every offered byte, optionally late, then acknowledges
   always
   begin
      @(posedge clk_in);
      if (tx_req_in === 1'b1)
      begin
         n = int'(tx_len_in);
         got.delete();
         repeat (slow) @(posedge clk_in);
         for (int i = 0; i < n; i++)
         begin
            pop_out <= 1'b1;
            @(posedge clk_in);
            pop_out <= 1'b0;
            @(posedge clk_in);
            got.push_back(tx_byte_in);
         end
         ack_out <= 1'b1;
         @(posedge clk_in);
         ack_out <= 1'b0;
      end
   end
endmodule

// >>> verif/tb.sv
// self-checking bench for the endpoint-zero control block
module tb
   import uep0_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, wr_s, rd_s, tok_v, rx_v, rx_done, pop, ack, tx_req, hs_v, irq, saw_tx;
   logic [7:0] addr, wd, rdata, rx_b, tx_byte;
   logic [1:0] tok_k, hs_c, mode, hs_last;
   logic [6:0] tx_len, len_last;
   logic ep0;
   int err_count = 0;
   int compares = 0;
   int cyc = 0;
   int hs_n, irq_n, req_n;
   uep0_ctrl dut (.CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wd),
      .REG_WR_IN(wr_s), .REG_RD_IN(rd_s), .REG_RDATA_OUT(rdata), .TOK_VALID_IN(tok_v),
      .TOK_KIND_IN(tok_k), .TOK_EP0_IN(ep0), .RX_BYTE_VALID_IN(rx_v), .RX_BYTE_IN(rx_b),
      .RX_DONE_IN(rx_done), .RX_BAD_IN(1'b0), .TX_POP_IN(pop), .TX_ACK_IN(ack),
      .TX_REQ_OUT(tx_req), .TX_LEN_OUT(tx_len), .TX_BYTE_OUT(tx_byte), .HS_VALID_OUT(hs_v),
      .HS_CODE_OUT(hs_c), .EP0_IRQ_OUT(irq), .MODE_OUT(mode));
   uep0_host host (.clk_in(clk), .tx_req_in(tx_req), .tx_len_in(tx_len), .tx_byte_in(tx_byte),
      .tok_v_out(tok_v), .tok_k_out(tok_k), .rx_v_out(rx_v), .rx_b_out(rx_b),
      .rx_done_out(rx_done), .pop_out(pop), .ack_out(ack));
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // one-cycle outputs are counted mid-cycle, away from the launching edge
   always @(negedge clk)
   begin
      if (hs_v === 1'b1)
      begin
         hs_n++;
         hs_last = hs_c;
      end
      if (irq === 1'b1)
         irq_n++;
      if (tx_req === 1'b1)
         len_last = tx_len;
      if (tx_req === 1'b1)
         req_n++;
      if (mode === MODE_TX)
         saw_tx = 1'b1;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         $display("BAD %0t timeout", $time);
         give_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
      compares++;
      if (g !== e)
      begin
         err_count++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wd <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic clr;
      hs_n = 0;
      irq_n = 0;
      req_n = 0;
      saw_tx = 1'b0;
   endtask
   task automatic setup_ok;
      host.send(TOK_SETUP, 8);
      wr(OFF_CSR, 8'h40);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic s_setup;
      logic [7:0] d;
      rd(OFF_CSR, d);
      chk(d, CSR_RESET, "csr reset");
      clr();
      host.send(TOK_SETUP, 8);
      wt(2);
      chk({6'h0, hs_last}, {6'h0, HS_ACK}, "setup ack");
      chk(8'(irq_n), 8'h01, "setup irq");
      rd(OFF_CSR, d);
      chk(d, 8'h01, "setup loaded");
      rd(OFF_COUNT, d);
      chk(d, 8'h08, "count");
      rd(OFF_FIFO, d);
      chk(d, 8'h00, "first byte");
      wr(OFF_CSR, 8'h40);
      rd(OFF_CSR, d);
      chk(d, 8'h00, "serviced");
      clr();
      // a token for another endpoint must draw no answer at all
      ep0 <= 1'b0;
      host.token(TOK_IN);
      ep0 <= 1'b1;
      host.send(TOK_SETUP, 7);
      wt(3);
      chk(8'(hs_n + irq_n), 8'h00, "short setup");
   endtask
   task automatic s_in;
      logic [7:0] d;
      clr();
      host.token(TOK_IN);
      wt(2);
      chk({6'h0, hs_last}, {6'h0, HS_NAK}, "nak");
      chk(8'(irq_n), 8'h00, "nak irq");
      chk(8'(req_n), 8'h00, "nak no data");
      for (int i = 0; i < 3; i++)
         wr(OFF_FIFO, 8'(8'hA0 + i));
      wr(OFF_CSR, 8'h0A);
      clr();
      host.token(TOK_IN);
      for (int i = 0; i < 300 && irq_n == 0; i++)
         @(posedge clk);
      wt(2);
      chk({1'b0, len_last}, 8'h03, "length");
      chk(host.got[2], 8'hA2, "third byte");
      chk(8'(irq_n), 8'h01, "sent irq");
      chk(8'(req_n), 8'h01, "one request");
      chk(8'(saw_tx), 8'h01, "tx mode");
      chk({6'h0, mode}, {6'h0, MODE_IDLE}, "short ends tx");
      rd(OFF_CSR, d);
      chk(d, 8'h00, "in cleared");
   endtask
   task automatic s_setup_end_flag;
      logic [7:0] d;
      host.slow = 4;
      for (int i = 0; i < 64; i++)
         wr(OFF_FIFO, 8'(i));
      wr(OFF_CSR, 8'h02);
      clr();
      host.token(TOK_IN);
      for (int i = 0; i < 400 && irq_n == 0; i++)
         @(posedge clk);
      wt(2);
      chk({6'h0, mode}, {6'h0, MODE_TX}, "full keeps tx");
      chk(host.got[63], 8'h3F, "last byte");
      host.slow = 0;
      clr();
      host.send(TOK_OUT, 0);
      wt(2);
      rd(OFF_CSR, d);
      chk(d & 8'h10, 8'h10, "setup end");
      chk(8'(irq_n > 0), 8'h01, "early end irq");
      wr(OFF_CSR, 8'hC0);
      rd(OFF_CSR, d);
      chk(d & 8'hD1, 8'h00, "setup end acked");
   endtask
   task automatic s_stall;
      logic [7:0] d;
      setup_ok();
      host.send(TOK_OUT, 64);
      wt(2);
      chk({6'h0, mode}, {6'h0, MODE_RX}, "rx mode");
      rd(OFF_COUNT, d);
      chk(d, 8'h40, "out count");
      rd(OFF_FIFO, d);
      chk(d, 8'h00, "out byte");
      wr(OFF_CSR, 8'h40);
      host.send(TOK_OUT, 0);
      wt(2);
      chk({6'h0, mode}, {6'h0, MODE_IDLE}, "empty ends rx");
      wr(OFF_CSR, 8'h48);
      clr();
      host.send(TOK_OUT, 4);
      wt(2);
      chk({6'h0, hs_last}, {6'h0, HS_STALL}, "late out");
      chk(8'(irq_n > 0), 8'h01, "stall irq");
      rd(OFF_CSR, d);
      chk(d & 8'h04, 8'h04, "stall sent");
      wr(OFF_CSR, 8'h00);
      setup_ok();
      wr(OFF_CSR, 8'h20);
      clr();
      host.token(TOK_IN);
      wt(2);
      chk({6'h0, hs_last}, {6'h0, HS_STALL}, "forced");
      rd(OFF_CSR, d);
      chk(d & 8'h24, 8'h04, "force cleared");
      wr(OFF_CSR, 8'h00);
      setup_ok();
      clr();
      host.send(TOK_OUT, 65);
      wt(2);
      chk({6'h0, hs_last}, {6'h0, HS_STALL}, "oversize");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst = 1'b1;
      wr_s = 1'b0;
      rd_s = 1'b0;
      addr = 8'h00;
      wd = 8'h00;
      ep0 = 1'b1;
      clr();
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      s_setup();
      s_in();
      s_setup_end_flag();
      s_stall();
      give_verdict();
   end
endmodule
